// ### hw/eep_i2c_slave.sv
// eep_i2c_slave: bus-facing transaction logic of a serial eeprom
// assumes scl, sda, straps and protect arrive unsynchronised from pins;
// sda is open drain: o_sda_oe high pulls the line low
module eep_i2c_slave
    import eep_pkg::*;
#(
    parameter int unsigned P_WRITE_CYCLES = WRITE_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_chip_select_bit0,
    input wire logic i_chip_select_bit1,
    input wire logic i_chip_select_bit2,
    input wire logic i_write_protect,
    output logic o_write_busy
);

    // ==========================================
    // declarations
    logic [5:0] pin_s1;
    logic [5:0] pin_s2;
    logic scl_d;
    logic sda_d;
    logic scl;
    logic sda;
    logic [2:0] chip_sel;
    logic wp_pin;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    eep_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic master_ack;
    logic first_data;
    logic wp_hold;
    logic byte_end;
    logic slot_end;
    logic dev_match;
    logic wp_block;
    logic store;
    logic load_tx;

    logic [4:0] addr_hi;
    logic [ADDR_W-1:0] cur_addr;

    logic [7:0] pb_data [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pb_valid;

    logic [7:0] mem [MEM_BYTES] = '{default: ERASED};
    logic [5:0] commit_idx;
    logic [31:0] wr_timer;
    logic commit_done;

    logic [ADDR_W-1:0] fetch_addr;
    logic inflight;
    logic [7:0] rd_data;
    logic buf_flush;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [7:0] buf_out_data;
    logic inflight_issue;

    // ==========================================
    // pin synchronisers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
        end else begin
            pin_s1 <= {i_write_protect, i_chip_select_bit2, i_chip_select_bit1,
                       i_chip_select_bit0, i_sda, i_scl};
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= pin_s2[0];
            sda_d <= pin_s2[1];
        end
    end

    assign scl = pin_s2[0];
    assign sda = pin_s2[1];
    assign chip_sel = pin_s2[4:2];
    assign wp_pin = pin_s2[5];

    // bus events, sampled on scl rise, driven after scl fall
    assign scl_rise = scl && !scl_d;
    assign scl_fall = !scl && scl_d;
    assign bus_start = scl && scl_d && sda_d && !sda;
    assign bus_stop = scl && scl_d && !sda_d && sda;

    // ==========================================
    // bit counter and receive shifter
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || bus_start || bus_stop) begin
            bit_cnt <= 4'h0;
        end else if (scl_rise && bit_cnt <= BIT_LAST) begin
            bit_cnt <= 4'(bit_cnt + 4'h1);
        end else if (scl_fall && bit_cnt == ACK_SLOT) begin
            bit_cnt <= 4'h0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rx_byte <= 8'h00;
        end else if (scl_rise && bit_cnt < BIT_LAST) begin
            rx_byte <= {rx_byte[6:0], sda};
        end
    end

    assign byte_end = scl_fall && (bit_cnt == BIT_LAST);
    assign slot_end = scl_fall && (bit_cnt == ACK_SLOT);
    assign dev_match = (rx_byte[7:4] == DEV_TYPE) && (rx_byte[3:1] == chip_sel);
    assign wp_block = first_data && wp_hold;
    assign store = byte_end && (state == ST_WDAT) && !wp_block;
    assign load_tx = slot_end && (state == ST_RDAT) && master_ack;

    // ==========================================
    // transaction sequencer and sda drive
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state <= ST_IDLE;
            o_sda_oe <= 1'b0;
            master_ack <= 1'b0;
            first_data <= 1'b0;
            wp_hold <= 1'b0;
            tx_byte <= 8'h00;
        end else if (bus_start) begin
            state <= ST_DEV;
            o_sda_oe <= 1'b0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
            o_sda_oe <= 1'b0;
        end else if (byte_end) begin
            unique case (state)
                ST_DEV: begin
                    // busy device stays silent so the master polls
                    if (dev_match && !o_write_busy) begin
                        o_sda_oe <= 1'b1;
                        state <= rx_byte[0] ? ST_RDAT : ST_AHI;
                        master_ack <= 1'b1;
                    end else begin
                        state <= ST_SKIP;
                    end
                end
                ST_AHI: begin
                    o_sda_oe <= 1'b1;
                    state <= ST_ALO;
                end
                ST_ALO: begin
                    o_sda_oe <= 1'b1;
                    state <= ST_WDAT;
                    first_data <= 1'b1;
                end
                ST_WDAT: begin
                    first_data <= 1'b0;
                    if (wp_block) begin
                        state <= ST_SKIP;
                    end else begin
                        o_sda_oe <= 1'b1;
                    end
                end
                ST_RDAT: begin
                    o_sda_oe <= 1'b0;
                end
                ST_IDLE, ST_SKIP: begin
                    o_sda_oe <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    o_sda_oe <= 1'b0;
                end
            endcase
        end else if (scl_rise && bit_cnt == BIT_LAST && state == ST_RDAT) begin
            master_ack <= !sda;
        end else if (slot_end) begin
            o_sda_oe <= 1'b0;
            if (state == ST_WDAT && first_data) begin
                wp_hold <= wp_pin;
            end
            if (state == ST_RDAT) begin
                if (master_ack) begin
                    tx_byte <= buf_out_data;
                    o_sda_oe <= !buf_out_data[7];
                end else begin
                    state <= ST_SKIP;
                end
            end
        end else if (scl_fall && state == ST_RDAT && bit_cnt != 4'h0 && bit_cnt < BIT_LAST) begin
            o_sda_oe <= !tx_byte[6];
            tx_byte <= {tx_byte[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        o_sda <= 1'b0;
    end

    // ==========================================
    // address register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            addr_hi <= 5'h00;
            cur_addr <= '0;
        end else if (byte_end && state == ST_AHI) begin
            addr_hi <= rx_byte[4:0];
        end else if (byte_end && state == ST_ALO) begin
            cur_addr <= {addr_hi, rx_byte};
        end else if (store) begin
            cur_addr[PAGE_OFS_W-1:0] <= 5'(cur_addr[PAGE_OFS_W-1:0] + 5'h01);
        end else if (load_tx) begin
            cur_addr <= 13'(cur_addr + 13'h0001);
        end
    end

    // ==========================================
    // page buffer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || commit_done) begin
            pb_valid <= '0;
        end else if (!o_write_busy && (bus_start || (byte_end && state == ST_ALO))) begin
            pb_valid <= '0;
        end else if (store) begin
            pb_valid[cur_addr[PAGE_OFS_W-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (store) begin
            pb_data[cur_addr[PAGE_OFS_W-1:0]] <= rx_byte;
        end
    end

    // ==========================================
    // internal write cycle
    assign commit_done = o_write_busy && (wr_timer == 32'(P_WRITE_CYCLES - 1));

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_write_busy <= 1'b0;
            commit_idx <= 6'h00;
            wr_timer <= 32'h0000_0000;
        end else if (!o_write_busy) begin
            if (bus_stop && (|pb_valid)) begin
                o_write_busy <= 1'b1;
                commit_idx <= 6'h00;
                wr_timer <= 32'h0000_0000;
            end
        end else begin
            wr_timer <= 32'(wr_timer + 32'h0000_0001);
            if (!commit_idx[5]) begin
                commit_idx <= 6'(commit_idx + 6'h01);
            end
            if (commit_done) begin
                o_write_busy <= 1'b0;
            end
        end
    end

    // the page part of cur_addr cannot move while busy
    always_ff @(posedge i_ref_clk) begin
        if (o_write_busy && !commit_idx[5] && pb_valid[commit_idx[4:0]]) begin
            mem[{cur_addr[ADDR_W-1:PAGE_OFS_W], commit_idx[4:0]}] <=
                pb_data[commit_idx[4:0]];
        end else if (inflight_issue) begin
            rd_data <= mem[fetch_addr];
        end
    end

    // ==========================================
    // read prefetch into the two-entry buffer
    assign buf_flush = bus_start || bus_stop || (byte_end && state == ST_DEV);
    assign inflight_issue = (state == ST_RDAT) && buf_in_ready && !inflight && !buf_flush;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fetch_addr <= '0;
            inflight <= 1'b0;
        end else if (buf_flush) begin
            fetch_addr <= cur_addr;
            inflight <= 1'b0;
        end else if (inflight_issue) begin
            fetch_addr <= 13'(fetch_addr + 13'h0001);
            inflight <= 1'b1;
        end else begin
            inflight <= 1'b0;
        end
    end

    eep_pair_buf #(
        .WIDTH(8)
    ) u_read_buf (
        .i_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_flush(buf_flush),
        .i_in_valid(inflight),
        .o_in_ready(buf_in_ready),
        .i_in_data(rd_data),
        .o_out_valid(buf_out_valid),
        .i_out_ready(load_tx),
        .o_out_data(buf_out_data)
    );

    // ==========================================
    // checks
    a_busy_quiet: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_write_busy |-> !o_sda_oe)
        else $error("sda driven during internal write");

    a_stop_commit: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (bus_stop && (|pb_valid) && !o_write_busy) |=> o_write_busy ##1 o_write_busy[*8])
        else $error("stop did not launch a lasting write cycle");

    a_wp_reject: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (byte_end && state == ST_WDAT && first_data && wp_hold)
        |=> (!o_sda_oe && state == ST_SKIP))
        else $error("protected write was acknowledged");

    a_addr_ack: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (byte_end && (state == ST_AHI || state == ST_ALO)) |=> o_sda_oe)
        else $error("address byte not acknowledged");

    a_foreign_nack: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (byte_end && state == ST_DEV && rx_byte[7:4] != DEV_TYPE) |=> !o_sda_oe)
        else $error("foreign device address acknowledged");

    a_page_fixed: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        store |=> (cur_addr[12:5] == $past(cur_addr[12:5]))
              && (cur_addr[4:0] == 5'($past(cur_addr[4:0]) + 5'h01)))
        else $error("page offset did not wrap within page");

    a_read_step: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        load_tx |=> (cur_addr == 13'($past(cur_addr) + 13'h0001)))
        else $error("read address did not advance by one");

    a_idle_free: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state == ST_IDLE) |-> !o_sda_oe)
        else $error("sda driven in standby");

    a_read_ready: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        load_tx |-> buf_out_valid)
        else $error("read byte loaded before prefetch");

endmodule

// ### hw/eep_pkg.sv
// eep_pkg: constants and types shared by the serial eeprom slave
// assumes a 250 MHz reference clock that samples all bus pins
//
// Functional notes
// - byte write: address, two address bytes, data
// - acknowledge all write bytes when idle
// - stop starts write cycle, bus ignored
// - page buffer holds up to 32 bytes
// - page fixed, in-page offset wraps around
// - whole page committed in one cycle
// - write protect high blocks all writes
// - protect pin sampled before first data
// - protected write: no ack, request dropped
// - unwritten array bytes read as FFh
// - read address acked, current byte sent
// - nack then stop returns to standby
// - selective read loads address, restarts read
// - selective read sends newly loaded byte
// - master ack keeps bytes streaming out
// - sequential read wraps whole address range
// - respond only to 1010 and straps
// - ninth clock carries the acknowledge
// - sample on rise, drive after fall
package eep_pkg;

    // ==========================================
    // array geometry
    localparam int ADDR_W = 13;
    localparam int PAGE_OFS_W = 5;
    localparam int MEM_BYTES = 8192;
    localparam int PAGE_BYTES = 32;
    localparam logic [7:0] ERASED = 8'hFF;

    // ==========================================
    // bus framing
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [5:0] PIN_IDLE = 6'h03;
    localparam logic [1:0] BUF_FULL = 2'h2;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int INTERNAL_WRITE_TIME_MS = 4;
    localparam int WRITE_CYCLES = INTERNAL_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================
    // transaction states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEV  = 7'h02,
        ST_AHI  = 7'h04,
        ST_ALO  = 7'h08,
        ST_WDAT = 7'h10,
        ST_RDAT = 7'h20,
        ST_SKIP = 7'h40
    } eep_state_e;

endpackage

// ### hw/eep_pair_buf.sv
// eep_pair_buf: two-entry valid/ready buffer with flush
// assumes one clock; flush drops both entries at once
module eep_pair_buf
    import eep_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    logic [WIDTH-1:0] slot [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign o_in_ready = (count != BUF_FULL);
    assign o_out_valid = (count != 2'h0);
    assign o_out_data = slot[rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // ==========================================
    // storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            slot[wr_ptr] <= i_in_data;
        end
    end

    // ==========================================
    // pointers and fill level
    always_ff @(posedge i_clk) begin
        if (i_reset || i_flush) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= 2'(count + {1'b0, push} - {1'b0, pop});
        end
    end

    a_buf_full_stall: assert property (@(posedge i_clk) disable iff (i_reset)
        (count == BUF_FULL && !i_out_ready && !i_flush)
        |=> (count == BUF_FULL) && (o_out_data == $past(o_out_data)))
        else $error("buffer lost a word while stalled");

    a_buf_fill_step: assert property (@(posedge i_clk) disable iff (i_reset)
        (push && !pop && !i_flush) |=> (count == 2'($past(count) + 2'h1)))
        else $error("buffer level did not rise on push");

endmodule

// ### tb/eep_master.sv
// eep_master: behavioural i2c bus master driving scl and an sda pull
// assumes the bench resolves the sda wire with a pull-up
module eep_master (
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================
    // bus clock: 20 reference clocks, idle high between frames
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end

    task automatic q(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    // data changes only while scl is low, sampled mid-high
    task automatic bitx(input logic b, output logic r);
        o_pull = !b;
        q(5);
        o_scl = 1'b1;
        q(5);
        r = i_sda;
        q(5);
        o_scl = 1'b0;
        q(5);
    endtask

    // also serves as repeated start from scl low
    task automatic start();
        o_pull = 1'b0;
        q(5);
        o_scl = 1'b1;
        q(5);
        o_pull = 1'b1;
        q(5);
        o_scl = 1'b0;
        q(5);
    endtask

    task automatic stop();
        o_pull = 1'b1;
        q(5);
        o_scl = 1'b1;
        q(5);
        o_pull = 1'b0;
        q(10);
    endtask

    // ninth clock released so the slave can answer
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = !r;
    endtask

    task automatic rd(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(!ack, r);
    endtask
endmodule

// ### tb/tb.sv
// tb: self-checking bench for the eeprom i2c slave
// assumes eep_master as bus master and a pulled-up sda wire
module tb;
    import eep_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wp = 1'b0;
    logic [2:0] cs = 3'h5;
    logic oe, so, busy, scl, pull, sda;
    int errors = 0;
    int n_checks = 0;
    logic [7:0] mem [MEM_BYTES];

    always #2 ref_clk = ~ref_clk;
    assign sda = (oe ? so : 1'b1) && !pull;

    eep_i2c_slave #(.P_WRITE_CYCLES(400)) dut (.i_ref_clk(ref_clk), .i_reset(rst),
        .i_scl(scl), .i_sda(sda), .o_sda(so), .o_sda_oe(oe),
        .i_chip_select_bit0(cs[0]), .i_chip_select_bit1(cs[1]),
        .i_chip_select_bit2(cs[2]), .i_write_protect(wp), .o_write_busy(busy));
    eep_master mst (.i_ref_clk(ref_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));

    // ==========================================
    // checking and closing
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================
    // bus helpers
    function automatic logic [7:0] dev(input logic rd);
        return {DEV_TYPE, cs, rd};
    endfunction

    task automatic seek(input logic [15:0] a);
        logic k;
        mst.start();
        mst.wr(dev(1'b0), k);
        chk("dev ack", k, 1);
        mst.wr(a[15:8], k);
        chk("ahi ack", k, 1);
        mst.wr(a[7:0], k);
        chk("alo ack", k, 1);
    endtask

    // gap stalls the bus with scl low ahead of each byte
    task automatic rd_seq(input logic [12:0] a, input int n, input int gap);
        logic k;
        logic [7:0] d;
        mst.start();
        mst.wr(dev(1'b1), k);
        chk("rd ack", k, 1);
        for (int i = 0; i < n; i++) begin
            if (gap > 0) mst.q(gap);
            mst.rd(d, i < n - 1);
            chk("rd data", d, mem[a]);
            a = a + 13'h1;
        end
        mst.stop();
        chk("released", oe, 0);
        chk("sda value", so, 0);
    endtask

    task automatic wait_write();
        int n;
        logic k;
        chk("busy", busy, 1);
        for (n = 0; n < 40; n++) begin
            mst.start();
            mst.wr(dev(1'b0), k);
            mst.stop();
            if (n == 0) chk("poll nack", k, 0);
            if (k) break;
        end
        if (n == 40) begin
            errors++;
            finish_test();
        end
    endtask

    task automatic wr_page(input logic [15:0] a, input int n, input logic [7:0] base);
        logic k;
        logic [7:0] d;
        seek(a);
        for (int i = 0; i < n; i++) begin
            d = base + 8'(i);
            mst.wr(d, k);
            chk("data ack", k, 1);
            mem[{a[12:5], 5'(a[4:0] + i)}] = d;
        end
        mst.stop();
        wait_write();
    endtask

    // ==========================================
    // scenarios
    task automatic t_erased();
        seek(16'h0000);
        rd_seq(13'h0000, 2, 0);
    endtask

    task automatic t_byte();
        wr_page(16'hF234, 1, 8'h5A);
        seek(16'h1234);
        rd_seq(13'h1234, 1, 0);
    endtask

    task automatic t_page();
        wr_page(16'h005E, 34, 8'h10);
        rd_seq(13'h0040, 33, 0);
    endtask

    task automatic t_wrap();
        wr_page(16'h0000, 1, 8'hC3);
        seek(16'h1FFF);
        rd_seq(13'h1FFF, 3, 300);
    endtask

    task automatic t_protect();
        logic k;
        wp = 1'b1;
        seek(16'h0100);
        wp = 1'b0;
        mst.wr(8'h77, k);
        chk("wp nack", k, 0);
        mst.stop();
        mst.q(20);
        chk("no write", busy, 0);
        seek(16'h0101);
        wp = 1'b1;
        mst.wr(8'h66, k);
        chk("late wp ack", k, 1);
        mem[13'h0101] = 8'h66;
        mst.stop();
        wp = 1'b0;
        wait_write();
        seek(16'h0100);
        rd_seq(13'h0100, 2, 0);
    endtask

    task automatic t_select();
        logic k;
        for (int i = 0; i < 4; i++) begin
            mst.start();
            mst.wr(dev(1'b1) ^ (8'h02 << i), k);
            chk("foreign nack", k, 0);
            mst.stop();
        end
    endtask

    initial begin
        foreach (mem[i]) mem[i] = ERASED;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        mst.q(3);
        t_erased();
        t_byte();
        t_page();
        t_wrap();
        t_protect();
        t_select();
        finish_test();
    end
endmodule
